// >>> hdl/rcr_pkg.sv
// Constants and types shared by the recovered clock output router.
// Assumes an APB host on clk_sys and recovered channel clocks from the line side.
package rcr_pkg;

	// Word indices of the registers; byte address is four times the index
	localparam logic [9:0] RCR_IDX_ROUTE_2_3 = 10'h0d3;
	localparam logic [9:0] RCR_IDX_ROUTE_4_5 = 10'h0d4;
	localparam logic [9:0] RCR_IDX_ROUTE_6_7 = 10'h0d5;
	localparam logic [9:0] RCR_IDX_ROUTE_8_MODE = 10'h0d6;
	localparam logic [9:0] RCR_IDX_CTRL = 10'h0e0;
	localparam logic [9:0] RCR_IDX_STATUS = 10'h0e1;

	localparam int RCR_NUM_CHAN = 8;
	localparam int RCR_NUM_OUT = 7;
	localparam int RCR_NUM_ROUTE = 4;
	localparam int RCR_SEL_W = 3;
	localparam int RCR_ADDR_W = 12;

	// Reset values of the routing registers and the legacy flag, and the routing write mask
	localparam logic [7:0] RCR_RST_ROUTE_2_3 = 8'h21;
	localparam logic [7:0] RCR_RST_ROUTE_4_5 = 8'h43;
	localparam logic [7:0] RCR_RST_ROUTE_6_7 = 8'h65;
	localparam logic [7:0] RCR_RST_ROUTE_8_MODE = 8'h07;
	localparam logic [7:0] RCR_ROUTE_MASK = 8'h77;
	localparam logic RCR_RST_LEGACY = 1'b0;

	// Field positions
	localparam int RCR_POS_SEL_LO = 0;
	localparam int RCR_POS_SEL_HI = 4;
	localparam int RCR_POS_MODE = 4;
	localparam int RCR_POS_LEGACY = 0;
	localparam int RCR_POS_ST_PEND = 0;
	localparam int RCR_POS_ST_MODE = 1;
	localparam int RCR_POS_ST_RSVD = 4;

	// Multiplex mode codes
	localparam logic [2:0] RCR_MODE_LEGACY = 3'h0;
	localparam logic [2:0] RCR_MODE_WIDE = 3'h1;

	// Depth of every synchroniser chain
	localparam int RCR_SYNC_STAGES = 2;

	typedef logic [RCR_SEL_W-1:0] rcr_sel_t;

endpackage

// >>> hdl/rcr_route_mux.sv
// One output of the router: picks a channel clock or the legacy own channel.
// Assumes synchronised channel levels; output is combinational, registered by the caller.
`timescale 1ns/1ps
module rcr_route_mux
	import rcr_pkg::*;
#(
	parameter int OWN_CHAN = 0
)
(
	input  wire logic [RCR_NUM_CHAN-1:0] chan,
	input  wire rcr_sel_t                sel,
	input  wire logic                    legacy,
	output logic                         route_out
);

	always_comb
	begin
		if (legacy)
			route_out = chan[OWN_CHAN];
		else
			route_out = chan[sel];
	end

endmodule

// >>> hdl/rcr_sync.sv
// Two-stage level synchroniser for a bus of independent bits.
// Assumes each bit is a level or a toggle that may be seen a cycle late.
`timescale 1ns/1ps
module rcr_sync
	import rcr_pkg::*;
#(
	parameter int W = 1
)
(
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_reg;

	// First stage feeds the second and nothing else
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			meta_reg <= '0;
			q <= '0;
		end
		else
		begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end

endmodule

// >>> hdl/rcr_top.sv
// Recovered clock output router: APB registers, config crossing, link-side selection.
// Assumes an APB4 master on clk_sys and channel clocks sampled by the free-running clk_link.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
module rcr_top
	import rcr_pkg::*;
(
	input  wire logic                    clk_sys,
	input  wire logic                    rst_b,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [RCR_ADDR_W-1:0]   paddr,
	input  wire logic [31:0]             pwdata,
	input  wire logic [3:0]              pstrb,
	output logic                         pready,
	output logic [31:0]                  prdata,
	output logic                         pslverr,
	input  wire logic                    clk_link,
	input  wire logic [RCR_NUM_CHAN-1:0] rx_chan_clk,
	output logic                         recovered_clock_out_2,
	output logic                         recovered_clock_out_3,
	output logic                         recovered_clock_out_4,
	output logic                         recovered_clock_out_5,
	output logic                         recovered_clock_out_6,
	output logic                         recovered_clock_out_7,
	output logic                         recovered_clock_out_8,
	output logic [2:0]                   wide_mux_mode_sel,
	output logic                         wide_mux_active
);

	localparam int CFG_W = RCR_NUM_OUT * RCR_SEL_W + 1;

	// Register index of an APB byte address; the two low address bits are dropped
	function automatic logic [9:0] reg_index(input logic [RCR_ADDR_W-1:0] addr);
		reg_index = addr[RCR_ADDR_W-1:2];
	endfunction

	// Routing register slot of a byte address, or RCR_NUM_ROUTE when it is none or misaligned
	function automatic logic [2:0] route_slot(input logic [RCR_ADDR_W-1:0] addr);
		logic [9:0] idx;
		idx = reg_index(addr);
		if (addr[1:0] != 2'h0)
			route_slot = 3'(RCR_NUM_ROUTE);
		else if (idx == RCR_IDX_ROUTE_2_3)
			route_slot = 3'h0;
		else if (idx == RCR_IDX_ROUTE_4_5)
			route_slot = 3'h1;
		else if (idx == RCR_IDX_ROUTE_6_7)
			route_slot = 3'h2;
		else if (idx == RCR_IDX_ROUTE_8_MODE)
			route_slot = 3'h3;
		else
			route_slot = 3'(RCR_NUM_ROUTE);
	endfunction

	function automatic logic is_idx(input logic [RCR_ADDR_W-1:0] addr, input logic [9:0] idx);
		is_idx = (addr[1:0] == 2'h0) && (reg_index(addr) == idx);
	endfunction

	logic [7:0]       route_reg [RCR_NUM_ROUTE];
	logic             legacy_reg;
	logic             dirty_reg;
	logic             busy_reg;
	logic             req_tgl_reg;
	logic [CFG_W-1:0] shadow_reg;
	logic [2:0]       mode_reg;
	logic             ack_sync;
	logic             addr_hit;
	logic             wr_en;
	logic             wr_cfg;
	logic [2:0]       wr_slot;
	logic [2:0]       mode_field;
	logic             mode_rsvd;
	rcr_sel_t         sel_sys [RCR_NUM_OUT];
	logic [CFG_W-1:0] cfg_now;
	logic [31:0]      rd_value;

	// Link domain state
	logic             link_rst_meta_reg;
	logic             link_rst_b_reg;
	logic             req_sync;
	logic             ack_tgl_reg;
	rcr_sel_t         link_sel_reg [RCR_NUM_OUT];
	logic             link_legacy_reg;
	logic [RCR_NUM_CHAN-1:0] chan_sync;
	logic [RCR_NUM_OUT-1:0]  route_comb;
	logic [RCR_NUM_OUT-1:0]  route_out_reg;

	// APB slave: no wait states, error on any unmapped or misaligned word
	assign wr_slot = route_slot(paddr);
	assign addr_hit = (wr_slot != 3'(RCR_NUM_ROUTE)) || is_idx(paddr, RCR_IDX_CTRL)
		|| is_idx(paddr, RCR_IDX_STATUS);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_hit;
	assign wr_en = psel && penable && pwrite && addr_hit && pstrb[0];
	assign wr_cfg = wr_en && !is_idx(paddr, RCR_IDX_STATUS);

	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
		begin
			route_reg[0] <= RCR_RST_ROUTE_2_3;
			route_reg[1] <= RCR_RST_ROUTE_4_5;
			route_reg[2] <= RCR_RST_ROUTE_6_7;
			route_reg[3] <= RCR_RST_ROUTE_8_MODE;
		end
		else if (wr_en && (wr_slot != 3'(RCR_NUM_ROUTE)))
		begin
			route_reg[wr_slot[1:0]] <= pwdata[7:0] & RCR_ROUTE_MASK;
		end
	end

	// Legacy flag, routing applies only while zero
	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
			legacy_reg <= RCR_RST_LEGACY;
		else if (wr_en && is_idx(paddr, RCR_IDX_CTRL))
			legacy_reg <= pwdata[RCR_POS_LEGACY];
	end

	// Selector k sits in register k/2, low field for even k
	always_comb
	begin
		for (int k = 0; k < RCR_NUM_OUT; k++)
		begin
			if (k % 2 == 0)
				sel_sys[k] = route_reg[k / 2][RCR_POS_SEL_LO +: RCR_SEL_W];
			else
				sel_sys[k] = route_reg[k / 2][RCR_POS_SEL_HI +: RCR_SEL_W];
		end
	end

	always_comb
	begin
		cfg_now = '0;
		for (int k = 0; k < RCR_NUM_OUT; k++)
			cfg_now[k * RCR_SEL_W +: RCR_SEL_W] = sel_sys[k];
		cfg_now[CFG_W-1] = legacy_reg;
	end

	// Mode field of the fourth register
	assign mode_field = route_reg[3][RCR_POS_MODE +: 3];
	// Codes above wide mode are reserved
	assign mode_rsvd = (mode_field != RCR_MODE_LEGACY) && (mode_field != RCR_MODE_WIDE);

	// Reserved codes fall back to legacy multiplexing
	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
			mode_reg <= RCR_RST_ROUTE_8_MODE[RCR_POS_MODE +: 3];
		else if (mode_rsvd)
			mode_reg <= RCR_MODE_LEGACY;
		else
			mode_reg <= mode_field;
	end

	assign wide_mux_mode_sel = mode_reg;
	// Wide mode relies on software having set the 16 Mbit/s rate
	assign wide_mux_active = (mode_reg == RCR_MODE_WIDE);

	// Config handshake: shadow held stable while a request is in flight.
	// A write in the same cycle as the launch keeps dirty set, so no update is lost.
	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
			dirty_reg <= 1'b0;
		else if (wr_cfg)
			dirty_reg <= 1'b1;
		else if (!busy_reg)
			dirty_reg <= 1'b0;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
		begin
			busy_reg <= 1'b0;
			req_tgl_reg <= 1'b0;
		end
		else if (!busy_reg && dirty_reg)
		begin
			busy_reg <= 1'b1;
			req_tgl_reg <= !req_tgl_reg;
		end
		else if (busy_reg && (ack_sync == req_tgl_reg))
		begin
			busy_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
			shadow_reg <= '0;
		else if (!busy_reg && dirty_reg)
			shadow_reg <= cfg_now;
	end

	rcr_sync #(
		.W (1)
	) u_ack_sync (
		.clk   (clk_sys),
		.rst_b (rst_b),
		.d     (ack_tgl_reg),
		.q     (ack_sync)
	);

	// Read data registered in the setup phase so prdata comes from a flop
	// Reserved bits and unmapped words read as zero
	always_comb
	begin
		rd_value = '0;
		if (wr_slot != 3'(RCR_NUM_ROUTE))
			rd_value[7:0] = route_reg[wr_slot[1:0]];
		else if (is_idx(paddr, RCR_IDX_CTRL))
			rd_value[RCR_POS_LEGACY] = legacy_reg;
		// Status: pending, effective mode, reserved-code flag
		else if (is_idx(paddr, RCR_IDX_STATUS))
		begin
			rd_value[RCR_POS_ST_PEND] = busy_reg || dirty_reg;
			rd_value[RCR_POS_ST_MODE +: 3] = mode_reg;
			rd_value[RCR_POS_ST_RSVD] = mode_rsvd;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
			prdata <= '0;
		else if (psel && !penable && !pwrite)
			prdata <= rd_value;
	end

	// Link-side reset: a plain synchronous chain, released a few link edges late
	always_ff @(posedge clk_link)
	begin
		link_rst_meta_reg <= rst_b;
		link_rst_b_reg <= link_rst_meta_reg;
	end

	rcr_sync #(
		.W (1)
	) u_req_sync (
		.clk   (clk_link),
		.rst_b (link_rst_b_reg),
		.d     (req_tgl_reg),
		.q     (req_sync)
	);

	// Level compare, not edge: a request made before link reset release still lands
	always_ff @(posedge clk_link)
	begin
		if (!link_rst_b_reg)
			ack_tgl_reg <= 1'b0;
		else if (req_sync != ack_tgl_reg)
			ack_tgl_reg <= req_sync;
	end

	// Link copy of the selectors and legacy flag
	always_ff @(posedge clk_link)
	begin
		if (!link_rst_b_reg)
		begin
			link_sel_reg[0] <= RCR_RST_ROUTE_2_3[RCR_POS_SEL_LO +: RCR_SEL_W];
			link_sel_reg[1] <= RCR_RST_ROUTE_2_3[RCR_POS_SEL_HI +: RCR_SEL_W];
			link_sel_reg[2] <= RCR_RST_ROUTE_4_5[RCR_POS_SEL_LO +: RCR_SEL_W];
			link_sel_reg[3] <= RCR_RST_ROUTE_4_5[RCR_POS_SEL_HI +: RCR_SEL_W];
			link_sel_reg[4] <= RCR_RST_ROUTE_6_7[RCR_POS_SEL_LO +: RCR_SEL_W];
			link_sel_reg[5] <= RCR_RST_ROUTE_6_7[RCR_POS_SEL_HI +: RCR_SEL_W];
			link_sel_reg[6] <= RCR_RST_ROUTE_8_MODE[RCR_POS_SEL_LO +: RCR_SEL_W];
			link_legacy_reg <= RCR_RST_LEGACY;
		end
		else if (req_sync != ack_tgl_reg)
		begin
			for (int k = 0; k < RCR_NUM_OUT; k++)
				link_sel_reg[k] <= shadow_reg[k * RCR_SEL_W +: RCR_SEL_W];
			link_legacy_reg <= shadow_reg[CFG_W-1];
		end
	end

	// Channel clocks are foreign to clk_link and pass two stages first
	rcr_sync #(
		.W (RCR_NUM_CHAN)
	) u_chan_sync (
		.clk   (clk_link),
		.rst_b (link_rst_b_reg),
		.d     (rx_chan_clk),
		.q     (chan_sync)
	);

	// Output k+2 from code plus one
	// Legacy ties output k+2 to its own channel
	// Code 111 on output 8 is taken as channel 8, still to be confirmed
	generate
		for (genvar k = 0; k < RCR_NUM_OUT; k++)
		begin : g_route
			rcr_route_mux #(
				.OWN_CHAN (k + 1)
			) u_mux (
				.chan      (chan_sync),
				.sel       (link_sel_reg[k]),
				.legacy    (link_legacy_reg),
				.route_out (route_comb[k])
			);
		end
	endgenerate

	// Registered so the outputs are glitch-free when a selector changes
	always_ff @(posedge clk_link)
	begin
		if (!link_rst_b_reg)
			route_out_reg <= '0;
		else
			route_out_reg <= route_comb;
	end

	assign recovered_clock_out_2 = route_out_reg[0];
	assign recovered_clock_out_3 = route_out_reg[1];
	assign recovered_clock_out_4 = route_out_reg[2];
	assign recovered_clock_out_5 = route_out_reg[3];
	assign recovered_clock_out_6 = route_out_reg[4];
	assign recovered_clock_out_7 = route_out_reg[5];
	assign recovered_clock_out_8 = route_out_reg[6];

endmodule

// >>> sim/rcr_chan_model.sv
// Line-side stand-in: drives channel clocks, samples the routed outputs.
// Assumes requested levels are applied at the next clk_link edge.
`timescale 1ns/1ps
module rcr_chan_model
	import rcr_pkg::*;
(
	input  wire logic                    clk_link,
	input  wire logic [RCR_NUM_CHAN-1:0] level_req,
	input  wire logic [RCR_NUM_OUT-1:0]  rclk_in,
	output logic      [RCR_NUM_CHAN-1:0] rx_chan_clk,
	output logic      [RCR_NUM_OUT-1:0]  seen
);
	// Launch on the link clock so the router never sees a mid-cycle change
	always_ff @(posedge clk_link)
	begin
		rx_chan_clk <= level_req;
	end
	always_ff @(posedge clk_link)
	begin
		seen <= rclk_in;
	end
endmodule

// >>> sim/rcr_top_properties.sv
// Port checks for rcr_top: refusals, read-back masking, mode and reset.
// Bound into rcr_top; clk_link is unrelated in phase to clk_sys.
`timescale 1ns/1ps
module rcr_top_properties
	import rcr_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        rst_b,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire logic        clk_link,
	input wire logic        recovered_clock_out_2,
	input wire logic        recovered_clock_out_8,
	input wire logic [2:0]  wide_mux_mode_sel,
	input wire logic        wide_mux_active
);
	sequence s_acc;
		psel && penable;
	endsequence
	sequence s_mode_wr;
		s_acc ##0 (pwrite && pstrb[0] && paddr == 12'h358);
	endsequence

	a_misaligned_err: assert property (@(posedge clk_sys) disable iff (!rst_b)
		s_acc ##0 (paddr[1:0] != 2'h0) |-> pslverr) else $error("misaligned access accepted");
	a_route_masked: assert property (@(posedge clk_sys) disable iff (!rst_b)
		s_acc ##0 (!pwrite && paddr >= 12'h34c && paddr <= 12'h358)
		|-> (prdata & 32'hffffff88) == 32'h0) else $error("unused bits read nonzero");
	a_mode_legal: assert property (@(posedge clk_sys) disable iff (!rst_b)
		wide_mux_mode_sel[2:1] == 2'h0) else $error("reserved mode code shown");
	a_active_decode: assert property (@(posedge clk_sys) disable iff (!rst_b)
		wide_mux_active == (wide_mux_mode_sel == RCR_MODE_WIDE)) else $error("active flag wrong");
	a_mode_after_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$changed(wide_mux_mode_sel) |-> $past(psel, 2) && $past(penable, 2) && $past(pwrite, 2)
		&& $past(paddr, 2) == 12'h358) else $error("mode changed without a write");
	a_wide_select: assert property (@(posedge clk_sys) disable iff (!rst_b)
		s_mode_wr ##0 (pwdata[6:4] == RCR_MODE_WIDE) |-> ##3 wide_mux_active)
		else $error("wide mode not taken");
	a_rsvd_legacy: assert property (@(posedge clk_sys) disable iff (!rst_b)
		s_mode_wr ##0 (pwdata[6:5] != 2'h0) |-> ##3 (wide_mux_mode_sel == RCR_MODE_LEGACY))
		else $error("reserved mode not legacy");
	a_reset_clear: assert property (@(posedge clk_sys)
		!rst_b |=> (prdata == 32'h0 && !wide_mux_active)) else $error("reset state wrong");
	a_link_reset: assert property (@(posedge clk_link)
		!rst_b [*6] |-> !recovered_clock_out_2 && !recovered_clock_out_8)
		else $error("outputs active in reset");
endmodule

bind rcr_top rcr_top_properties u_props (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.prdata(prdata), .pslverr(pslverr), .clk_link(clk_link),
	.recovered_clock_out_2(recovered_clock_out_2),
	.recovered_clock_out_8(recovered_clock_out_8),
	.wide_mux_mode_sel(wide_mux_mode_sel), .wide_mux_active(wide_mux_active));

// >>> sim/tb_top.sv
// Self-checking bench for rcr_top: APB master, channel model, routing checks.
// Assumes the status pending bit clears once the link side has new routing.
`timescale 1ns/1ps
module tb_top
	import rcr_pkg::*;
;
	localparam logic [11:0] ADDR [4] = '{12'h34c, 12'h350, 12'h354, 12'h358};
	logic        clk_sys = 1'b1;
	logic        clk_link = 1'b0;
	logic        rst_b = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [3:0]  pstrb = 4'h0;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic [7:0]  rx_chan_clk;
	logic [7:0]  chan_req = 8'h0;
	logic [6:0]  rclk;
	logic [6:0]  seen;
	logic [2:0]  mode_sel;
	logic        mode_act;
	logic [7:0]  shadow [4];
	logic        legacy;
	logic [31:0] rdat;
	logic        rerr;
	int          fails = 0;
	int          num_checks = 0;
	int          seed = 32'hc809371e;

	always #25 clk_sys = ~clk_sys;
	always #3 clk_link = ~clk_link;

	rcr_top dut (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .clk_link(clk_link), .rx_chan_clk(rx_chan_clk),
		.recovered_clock_out_2(rclk[0]), .recovered_clock_out_3(rclk[1]),
		.recovered_clock_out_4(rclk[2]), .recovered_clock_out_5(rclk[3]),
		.recovered_clock_out_6(rclk[4]), .recovered_clock_out_7(rclk[5]),
		.recovered_clock_out_8(rclk[6]), .wide_mux_mode_sel(mode_sel),
		.wide_mux_active(mode_act));
	rcr_chan_model u_chan (.clk_link(clk_link), .level_req(chan_req), .rclk_in(rclk),
		.rx_chan_clk(rx_chan_clk), .seen(seen));

	task automatic results();
		if (fails == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch %0t register got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_out(input logic [6:0] got, input logic [6:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch %0t outputs got %b expected %b", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
		input logic [3:0] s);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		pstrb <= s;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1)
			@(posedge clk_sys);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, d, 4'h1);
	endtask
	task automatic rd(input logic [11:0] a);
		apb(1'b0, a, 8'h0, 4'h0);
	endtask
	// Program all selectors and the legacy flag, then wait for the link side
	task automatic load(input logic leg);
		int n;
		n = 0;
		for (int i = 0; i < 4; i++)
			wr(ADDR[i], shadow[i]);
		legacy = leg;
		wr(12'h380, {7'h0, leg});
		rd(12'h384);
		while (rdat[0] !== 1'b0 && n < 20)
		begin
			rd(12'h384);
			n++;
		end
		if (n == 20)
			fails++;
	endtask
	function automatic logic [6:0] exp_out(input logic [7:0] ch);
		logic [6:0] e;
		logic [2:0] s;
		for (int k = 0; k < 7; k++)
		begin
			s = k[0] ? shadow[k / 2][6:4] : shadow[k / 2][2:0];
			e[k] = legacy ? ch[k + 1] : ch[s];
		end
		return e;
	endfunction
	task automatic probe(input logic [7:0] pat);
		chan_req <= pat;
		repeat (2) @(posedge clk_sys);
		chk_out(seen, exp_out(pat));
	endtask
	task automatic chk_mode();
		logic [31:0] e;
		e = {27'h0, shadow[3][6:5] != 2'h0, 2'h0, shadow[3][6:4] == 3'h1, 1'b0};
		chk_reg({29'h0, mode_sel}, {31'h0, shadow[3][6:4] == 3'h1});
		chk_reg({31'h0, mode_act}, {31'h0, shadow[3][6:4] == 3'h1});
		rd(12'h384);
		chk_reg(rdat & 32'h1e, e);
	endtask

	initial
	begin
		#500000;
		fails++;
		results();
	end

	initial
	begin
		legacy = 1'b0;
		shadow = '{RCR_RST_ROUTE_2_3, RCR_RST_ROUTE_4_5, RCR_RST_ROUTE_6_7, RCR_RST_ROUTE_8_MODE};
		repeat (4) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		for (int i = 0; i < 4; i++)
		begin
			rd(ADDR[i]);
			chk_reg(rdat, {24'h0, shadow[i]});
		end
		rd(12'h380);
		chk_reg(rdat, 32'h0);
		probe(8'ha5);
		probe(8'h5a);
		// Every selector code on every output, both polarities
		for (int c = 0; c < 8; c++)
		begin
			for (int i = 0; i < 4; i++)
				shadow[i] = {1'b0, c[2:0], 1'b0, c[2:0]};
			shadow[3][6:4] = 3'h0;
			load(1'b0);
			probe(8'h01 << c);
			probe(~(8'h01 << c));
		end
		load(1'b1);
		probe(8'h96);
		probe(8'h69);
		// rate selector lives outside this block; assumed at 16 Mbit/s
		for (int m = 0; m < 8; m++)
		begin
			shadow[3] = {1'b0, m[2:0], 4'h7};
			load(1'b0);
			chk_mode();
		end
		for (int t = 0; t < 24; t++)
		begin
			for (int i = 0; i < 4; i++)
				shadow[i] = 8'($random(seed));
			load(($random(seed) & 32'h3) == 32'h0);
			probe(8'($random(seed)));
			probe(8'($random(seed)));
			for (int i = 0; i < 4; i++)
			begin
				rd(ADDR[i]);
				chk_reg(rdat, {24'h0, shadow[i] & 8'h77});
			end
			chk_mode();
		end
		wr(12'h34c, 8'hff);
		apb(1'b1, 12'h34c, 8'h00, 4'h0);
		rd(12'h34c);
		chk_reg(rdat, 32'h77);
		rd(12'h3fc);
		chk_reg({31'h0, rerr}, 32'h1);
		chk_reg(rdat, 32'h0);
		rd(12'h34e);
		chk_reg({31'h0, rerr}, 32'h1);
		results();
	end
endmodule
